// >>> ssc_host.sv
// Purpose: host side of the three-wire synth programming link
// Assumes: 80 ns shift clock, held low between words except while noise toggles it
// Notes: data line shows the inverted last bit after a framed word, low after noise
`timescale 1ns/10ps
module ssc_host
(
   output logic shift_clk,
   output logic serial_in_line,
   output logic load_strobe_n,
   output logic powerdown_pin
);
   // idle levels at time zero, loops powered by pin
   initial
   begin
      shift_clk = 1'b0;
      serial_in_line = 1'b0;
      load_strobe_n = 1'b1;
      powerdown_pin = 1'b1;
   end
   // one bit: set up data, then a shift clock rise
   task bit_out(input logic b);
      serial_in_line = b;
      #20 shift_clk = 1'b1;
      #40 shift_clk = 1'b0;
      #20;
   endtask
   // framed word: lead bits, then address and data msb first
   task send(input logic [21:0] w, input int lead);
      int i;
      #3 load_strobe_n = 1'b0;
      for (i = 0; i < lead; i++)
         bit_out(i[0]);
      for (i = 21; i >= 0; i--)
         bit_out(w[i]);
      load_strobe_n = 1'b1;
      serial_in_line = ~w[0];
      #40;
   endtask
   // clock and data activity while the strobe stays high
   task noise(input int n);
      int i;
      #3;
      for (i = 0; i < n; i++)
         bit_out(i[1]);
      serial_in_line = 1'b0;
   endtask
   // powerdown pin level
   task pin(input logic v);
      powerdown_pin <= v;
   endtask
endmodule

// >>> ssc_pkg.sv
// Purpose: shared types of the synth control block
// Assumes: constants come from ssc_regs.svh
// Notes: none
package ssc_pkg;
   typedef struct packed
   {
      logic [3:0]  addr;
      logic [17:0] data;
   } ssc_word_type;
   typedef enum logic [2:0]
   {
      SSC_OFF    = 3'b001,
      SSC_TUNE   = 3'b010,
      SSC_READY  = 3'b100
   } ssc_state_type;
endpackage

// >>> ssc_regfile.sv
// Purpose: sixteen 18-bit control words written from the serial link
// Assumes: one write port, one read port, registered read data
// Notes: reset clears every word
`timescale 1ns/10ps
module ssc_regfile
#(
   parameter int WIDTH = 18,
   parameter int DEPTH = 16
)
(
   input  wire logic                     hclk,
   input  wire logic                     hresetn,
   input  wire logic                     wr_en,
   input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
   input  wire logic [WIDTH-1:0]         wr_data,
   input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
   output logic      [WIDTH-1:0]         rd_data
);
   logic [WIDTH-1:0] mem [DEPTH];

   initial
   begin
      if (DEPTH < 2 || WIDTH < 1)
      begin
         $error("ssc_regfile: bad size");
      end
   end

   // write port
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         for (int i = 0; i < DEPTH; i++)
         begin
            mem[i] <= '0;
         end
      end
      else if (wr_en)
      begin
         mem[wr_addr] <= wr_data;
      end
   end

   // registered read port
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rd_data <= '0;
      end
      else
      begin
         rd_data <= mem[rd_addr];
      end
   end
endmodule

// >>> ssc_regs.svh
// Purpose: offsets, field positions and timing counts for the synth control
// Assumes: 125 MHz hclk, 32-bit AHB-Lite register window
// Notes: serial word is address in the top four bits, data below
`ifndef SSC_REGS_SVH
`define SSC_REGS_SVH
`define SSC_WORD_BITS       22
`define SSC_DATA_BITS       18
`define SSC_ADDR_BITS       4
`define SSC_NUM_REGS        16
`define SSC_ADDR_MAIN_CFG   4'h0
`define SSC_ADDR_PD_GAIN    4'h1
`define SSC_ADDR_POWER      4'h2
`define SSC_ADDR_N_HIGH     4'h3
`define SSC_ADDR_N_LOW      4'h4
`define SSC_ADDR_N_IF       4'h5
`define SSC_ADDR_R_HIGH     4'h6
`define SSC_ADDR_R_LOW      4'h7
`define SSC_ADDR_R_IF       4'h8
`define SSC_BIT_REF_HALVE   6
`define SSC_BIT_IFDIV_LO    10
`define SSC_BIT_RF_POWER    0
`define SSC_BIT_IF_POWER    1
// ahb byte offsets; serial register k sits at 4*k
`define SSC_OFF_STATUS      12'h040
`define SSC_OFF_CONTROL     12'h044
`define SSC_OFF_TUNE_COUNT  12'h048
`define SSC_PDN_NS          100
`define SSC_PDN_CYC         ((`SSC_PDN_NS * 125) / 1000)
`define SSC_PUP_US          100
`define SSC_PUP_CYC         (`SSC_PUP_US * 125)
`define SSC_PUP_PERIODS     50
`define SSC_TUNE_PERIODS    13
`endif

// >>> ssc_top.sv
// Purpose: serial control front end of a three-loop frequency synthesizer
// Assumes: hclk 125 MHz; shift clock, data, strobe and powerdown are async
// Notes: loop analog parts are outside; this drives their enables
// What this block does
// - a transfer is one 22-bit word of 4 address bits and 18 data bits.
// - with the strobe low, data is shifted in on each shift clock rise.
// - the strobe rising edge copies data into the addressed register.
// - with the strobe high, shift clock and data are ignored.
// - extra leading bits are allowed and do not disturb the word.
// - only one RF loop is active, the one whose divider was last written.
// - self-tuning starts on loop powerup and on a frequency change; a loop powered up while another is on gets no tune.
// - powerup is a pin rise or a write of 1 to both power bits.
// - powerdown is a pin fall or a write of 0 to both, off within 100 ns.
// - after powerup, ready within 100 us or 50 update periods.
// - RF loops halve the VCO before feedback division, IF does not.
// - the IF output divider divides by 1, 2, 4 or 8.
// - reference halving bit D6 of register 0 halves the reference input.
// - N dividers of high, low and IF loops live at addresses 3, 4, 5.
// - R dividers of high, low and IF loops live at addresses 6, 7, 8.
//
// Added by the designer: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`include "ssc_regs.svh"
module ssc_top
#(
   parameter int PUP_CYC = `SSC_PUP_CYC
)
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [11:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        shift_clk,
   input  wire logic        serial_in_line,
   input  wire logic        load_strobe_n,
   input  wire logic        powerdown_pin,
   output logic             rf_high_band_pll,
   output logic             rf_low_band_pll,
   output logic             if_pll_enable,
   output logic             rf_vco_halve,
   output logic             ref_input_halve,
   output logic [3:0]       if_out_divide,
   output logic             tune_start,
   output logic             synth_ready
);
   localparam int PDN_CYC = (`SSC_PDN_CYC < 1) ? 1 : `SSC_PDN_CYC;

   initial
   begin
      if (PUP_CYC < 2)
      begin
         $error("ssc_top: PUP_CYC too small");
      end
   end

   // two-flop synchronisers for the async pins
   logic [3:0] sync1;
   logic [3:0] sync2;
   logic       sclk_d;
   logic       sen_d;
   logic       pin_d;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sync1  <= 4'hE;
         sync2  <= 4'hE;
         sclk_d <= 1'b0;
         sen_d  <= 1'b1;
         pin_d  <= 1'b1;
      end
      else
      begin
         sync1  <= {powerdown_pin, load_strobe_n, serial_in_line, shift_clk};
         sync2  <= sync1;
         sclk_d <= sync2[0];
         sen_d  <= sync2[2];
         pin_d  <= sync2[3];
      end
   end

   logic sclk_rise;
   logic sen_rise;
   logic pin_rise;
   logic pin_fall;
   assign sclk_rise = sync2[0] & ~sclk_d & ~sync2[2];
   assign sen_rise  = sync2[2] & ~sen_d;
   assign pin_rise  = sync2[3] & ~pin_d;
   assign pin_fall  = ~sync2[3] & pin_d;

   // shift register keeps the newest 22 bits; older lead bits fall off
   logic [`SSC_WORD_BITS-1:0] shreg;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         shreg <= '0;
      end
      else if (sclk_rise)
      begin
         shreg <= {shreg[`SSC_WORD_BITS-2:0], sync2[1]};
      end
   end

   ssc_pkg::ssc_word_type word;
   assign word = ssc_pkg::ssc_word_type'(shreg);

   // register file write on strobe rise
   logic [17:0] rf_rd;
   logic [3:0]  rf_rd_addr;
   ssc_regfile #(.WIDTH(`SSC_DATA_BITS), .DEPTH(`SSC_NUM_REGS)) u_regs
   (
      .hclk    (hclk),
      .hresetn (hresetn),
      .wr_en   (sen_rise),
      .wr_addr (word.addr),
      .wr_data (word.data),
      .rd_addr (rf_rd_addr),
      .rd_data (rf_rd)
   );

   // control bits that steer loop outputs are kept locally too
   logic [17:0] main_cfg;
   logic        sel_high;
   logic        if_on;
   logic        rf_on;
   logic        freq_change;
   logic        sw_pup;
   logic        sw_pdn;
   assign sw_pup = sen_rise && word.addr == `SSC_ADDR_POWER
                   && word.data[`SSC_BIT_RF_POWER]
                   && word.data[`SSC_BIT_IF_POWER];
   assign sw_pdn = sen_rise && word.addr == `SSC_ADDR_POWER
                   && !word.data[`SSC_BIT_RF_POWER]
                   && !word.data[`SSC_BIT_IF_POWER];
   assign freq_change = sen_rise && word.addr >= `SSC_ADDR_N_HIGH
                        && word.addr <= `SSC_ADDR_R_IF;

   // rf loop selection by last divider write
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sel_high <= 1'b1;
         main_cfg <= '0;
      end
      else if (sen_rise)
      begin
         if (word.addr == `SSC_ADDR_N_HIGH || word.addr == `SSC_ADDR_R_HIGH)
         begin
            sel_high <= 1'b1;
         end
         else if (word.addr == `SSC_ADDR_N_LOW
                  || word.addr == `SSC_ADDR_R_LOW)
         begin
            sel_high <= 1'b0;
         end
         else if (word.addr == `SSC_ADDR_MAIN_CFG)
         begin
            main_cfg <= word.data;
         end
      end
   end

   // power bits; pin fall or write of 0 to both wins, then pin rise or write of 1 to both, then separate bit writes
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         if_on <= 1'b0;
         rf_on <= 1'b0;
      end
      else if (pin_fall || sw_pdn)
      begin
         if_on <= 1'b0;
         rf_on <= 1'b0;
      end
      else if (pin_rise || sw_pup)
      begin
         if_on <= 1'b1;
         rf_on <= 1'b1;
      end
      else if (sen_rise && word.addr == `SSC_ADDR_POWER)
      begin
         if_on <= word.data[`SSC_BIT_IF_POWER];
         rf_on <= word.data[`SSC_BIT_RF_POWER];
      end
   end

   // loop enables follow power state and pin directly, inside 100 ns
   logic pin_ok;
   assign pin_ok           = sync2[3];
   assign rf_high_band_pll = rf_on & pin_ok & sel_high;
   assign rf_low_band_pll  = rf_on & pin_ok & ~sel_high;
   assign if_pll_enable    = if_on & pin_ok;
   assign rf_vco_halve     = 1'b1;
   assign ref_input_halve  = main_cfg[`SSC_BIT_REF_HALVE];

   // if output divider: two-bit code to one of 1,2,4,8
   function automatic logic [3:0] ssc_div_decode(input logic [1:0] code);
      ssc_div_decode = 4'h1 << code;
   endfunction
   assign if_out_divide =
      ssc_div_decode(main_cfg[`SSC_BIT_IFDIV_LO +: 2]);

   // tuning and settle sequencer
   ssc_pkg::ssc_state_type state;
   logic [31:0]            settle_cnt;
   logic                   any_on;
   logic                   was_on;
   assign any_on = (if_on | rf_on) & pin_ok;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state      <= ssc_pkg::SSC_OFF;
         settle_cnt <= '0;
         was_on     <= 1'b0;
         tune_start <= 1'b0;
      end
      else
      begin
         was_on     <= any_on;
         tune_start <= 1'b0;
         if (!any_on)
         begin
            state <= ssc_pkg::SSC_OFF;
         end
         else if ((any_on && !was_on) || freq_change)
         begin
            state      <= ssc_pkg::SSC_TUNE;
            settle_cnt <= 32'(PUP_CYC - 1);
            tune_start <= 1'b1;
         end
         else
         begin
            case (state)
               ssc_pkg::SSC_TUNE:
               begin
                  if (settle_cnt == '0)
                  begin
                     state <= ssc_pkg::SSC_READY;
                  end
                  else
                  begin
                     settle_cnt <= settle_cnt - 32'd1;
                  end
               end
               default:
               begin
               end
            endcase
         end
      end
   end
   assign synth_ready = (state == ssc_pkg::SSC_READY);

   // ahb-lite slave: one wait-free data phase, registered read
   logic        rd_pend;
   logic [11:0] rd_addr_q;
   logic        take;
   assign take       = hsel & hready & htrans[1];
   assign rf_rd_addr = haddr[5:2];
   assign hreadyout  = 1'b1;
   assign hresp      = 1'b0;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rd_pend   <= 1'b0;
         rd_addr_q <= '0;
      end
      else
      begin
         rd_pend   <= take & ~hwrite;
         rd_addr_q <= haddr;
      end
   end

   // read data mux
   always_comb
   begin
      hrdata = 32'h0000_0000;
      if (!rd_pend)
      begin
         hrdata = 32'h0000_0000;
      end
      else if (rd_addr_q[11:6] == 6'h00)
      begin
         hrdata = {14'h0000, rf_rd};
      end
      else if (rd_addr_q == `SSC_OFF_STATUS)
      begin
         hrdata = {26'h0000000, state, synth_ready, sel_high, if_on};
      end
      else if (rd_addr_q == `SSC_OFF_CONTROL)
      begin
         hrdata = {30'h00000000, rf_on, if_on};
      end
      else if (rd_addr_q == `SSC_OFF_TUNE_COUNT)
      begin
         hrdata = settle_cnt;
      end
   end

   // assertions
   a_strobe_loads: assert property (
      @(posedge hclk) disable iff (!hresetn)
      sen_rise && word.addr == `SSC_ADDR_N_LOW |=> !sel_high)
      else $error("low band write did not select low loop");
   a_strobe_high: assert property (
      @(posedge hclk) disable iff (!hresetn)
      sen_rise && word.addr == `SSC_ADDR_R_HIGH |=> sel_high)
      else $error("high band write did not select high loop");
   a_one_rf: assert property (
      @(posedge hclk) disable iff (!hresetn)
      !(rf_high_band_pll && rf_low_band_pll))
      else $error("both rf loops active");
   a_pdn_fast: assert property (
      @(posedge hclk) disable iff (!hresetn)
      sw_pdn |-> ##[1:PDN_CYC] !if_pll_enable)
      else $error("powerdown too slow");
   a_pin_pdn: assert property (
      @(posedge hclk) disable iff (!hresetn)
      pin_fall |-> ##[1:PDN_CYC] !if_pll_enable)
      else $error("pin powerdown too slow");
   a_pup_tune: assert property (
      @(posedge hclk) disable iff (!hresetn)
      sw_pup && !any_on && pin_ok |-> ##2 tune_start)
      else $error("powerup did not start tuning");
   a_freq_tune: assert property (
      @(posedge hclk) disable iff (!hresetn)
      freq_change && any_on && was_on |=> tune_start)
      else $error("frequency change did not retune");
   a_hold_high: assert property (
      @(posedge hclk) disable iff (!hresetn)
      sync2[2] |=> $stable(shreg))
      else $error("shift while strobe high");
   a_shift_in: assert property (
      @(posedge hclk) disable iff (!hresetn)
      sclk_rise |=> shreg[0] == $past(sync2[1]))
      else $error("bit not shifted");
   a_halve_bit: assert property (
      @(posedge hclk) disable iff (!hresetn)
      sen_rise && word.addr == `SSC_ADDR_MAIN_CFG
      |=> ref_input_halve == $past(word.data[`SSC_BIT_REF_HALVE]))
      else $error("reference halving not applied");
endmodule

// >>> synth_serial_control_tb.sv
// Purpose: self-checking bench of the synth serial control
// Assumes: settle count shortened to PUP cycles
// Notes: the register window is read only from the bus
`timescale 1ns/10ps
`include "ssc_regs.svh"
module synth_serial_control_tb;
   localparam int PUP = 20;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [11:0] haddr;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] hwdata, hrdata, rd, r;
   logic        shift_clk, serial_in_line, load_strobe_n, powerdown_pin;
   logic        rf_high_band_pll, rf_low_band_pll, if_pll_enable;
   logic        rf_vco_halve, ref_input_halve, tune_start, synth_ready;
   logic [3:0]  if_out_divide;
   logic [17:0] d;
   logic        sel_hi;
   logic [31:0] seed = 32'h0000004C;
   int          n_fail, cmp_count, k, f, tune_cnt, tune_base;

   ssc_top #(.PUP_CYC(PUP)) dut_u
   (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
      .shift_clk, .serial_in_line, .load_strobe_n, .powerdown_pin,
      .rf_high_band_pll, .rf_low_band_pll, .if_pll_enable,
      .rf_vco_halve, .ref_input_halve, .if_out_divide,
      .tune_start, .synth_ready
   );
   ssc_host host_u
   (
      .shift_clk, .serial_in_line, .load_strobe_n, .powerdown_pin
   );

   // 125 MHz clock
   initial
   begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end

   // counts tune pulses; one cycle is too short to poll after a write
   always @(posedge hclk)
      if (tune_start === 1'b1)
         tune_cnt <= tune_cnt + 1;

   // xorshift source
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // one-hot divide setting for a field value
   function automatic logic [3:0] exp_div(input logic [1:0] v);
      case (v)
         2'h0: return 4'h1;
         2'h1: return 4'h2;
         2'h2: return 4'h4;
         default: return 4'h8;
      endcase
   endfunction
   // watched outputs by index
   function automatic logic pick(input int s);
      case (s)
         0: return tune_cnt != tune_base;
         1: return synth_ready;
         default: return if_pll_enable;
      endcase
   endfunction

   task close_out();
      $display("fails=%0d compares=%0d", n_fail, cmp_count);
      if (n_fail == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e)
      begin
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
         n_fail++;
      end
   endtask
   task give_up();
      n_fail++;
      close_out();
   endtask
   // single bus transfer, waits on hreadyout twice
   task ahb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      int i;
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      i = 0;
      do @(posedge hclk); while (hreadyout !== 1'b1 && ++i < 20);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1 && ++i < 20);
      rd = hrdata;
      if (i >= 20)
         give_up();
      chk(hresp, 0);
   endtask
   // bounded wait for an output level
   task wait_for(input int s, input logic v, input int lim);
      int i;
      i = 0;
      while (pick(s) !== v && i < lim)
      begin
         @(posedge hclk);
         i++;
      end
      if (i >= lim)
         give_up();
   endtask
   task wr(input logic [3:0] a, input logic [17:0] v, input int gap);
      tune_base = tune_cnt;
      r = rnd();
      host_u.send({a, v}, int'(r[1:0]));
      repeat (gap) @(posedge hclk);
   endtask
   task rdchk(input logic [3:0] a, input logic [31:0] e);
      repeat (8) @(posedge hclk);
      ahb(1'b0, {6'h00, a, 2'h0}, 32'h0);
      chk(rd, e);
   endtask

   // main sequence
   initial
   begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 12'h000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      chk({rf_high_band_pll, rf_low_band_pll, if_pll_enable}, 0);
      chk(rf_vco_halve, 1);
      ahb(1'b1, 12'h00C, 32'h0003FFFF);
      rdchk(4'h3, 32'h0);
      ahb(1'b0, 12'h0FC, 32'h0);
      chk(rd, 0);
      sel_hi = 1'b1;
      for (k = 3; k <= 8; k++)
      begin
         r = rnd();
         d = r[17:0];
         wr(k[3:0], d, 0);
         if (k == 3 || k == 6)
            sel_hi = 1'b1;
         else if (k == 4 || k == 7)
            sel_hi = 1'b0;
         rdchk(k[3:0], {14'h0, d});
         ahb(1'b0, 12'h040, 32'h0);
         chk(rd[1], sel_hi);
      end
      for (f = 0; f < 4; f++)
      begin
         d = 18'h0;
         d[11:10] = f[1:0];
         d[6] = f[0];
         wr(4'h0, d, 8);
         chk(if_out_divide, exp_div(f[1:0]));
         chk(ref_input_halve, f[0]);
      end
      wr(4'h2, 18'h3, 0);
      wait_for(0, 1'b1, 20);
      wait_for(1, 1'b1, PUP + 20);
      chk({rf_high_band_pll, rf_low_band_pll, if_pll_enable}, 3);
      wr(4'h3, 18'h00155, 0);
      wait_for(0, 1'b1, 20);
      chk({rf_high_band_pll, rf_low_band_pll}, 2);
      host_u.noise(30);
      rdchk(4'h3, 32'h155);
      wr(4'h2, 18'h0, 0);
      wait_for(2, 1'b0, 12);
      chk({rf_high_band_pll, rf_low_band_pll}, 0);
      wr(4'h2, 18'h3, 0);
      wait_for(1, 1'b1, PUP + 40);
      host_u.pin(1'b0);
      wait_for(2, 1'b0, 12);
      @(posedge hclk);
      chk(synth_ready, 0);
      tune_base = tune_cnt;
      host_u.pin(1'b1);
      wait_for(0, 1'b1, 20);
      wait_for(1, 1'b1, PUP + 20);
      chk(if_pll_enable, 1);
      close_out();
   end
endmodule
